// ===== occ_pkg.sv
// constants and types for the on/off switch cycle controller
`default_nettype none
package occ_pkg;
  localparam int CLK_HZ      = 100_000_000;
  localparam int F_PEAK_HZ   = 264_000;
  localparam int P_PEAK      = CLK_HZ / F_PEAK_HZ;
  localparam int JIT_PCT     = 3;
  localparam int JIT_CNT     = P_PEAK * JIT_PCT / 100;
  localparam int JIT_RATE_HZ = 1_000;
  localparam int JIT_STEP    = CLK_HZ / (JIT_RATE_HZ * 4 * JIT_CNT);
  localparam int DUTY_PCT    = 65;
  localparam int LEB_NS      = 200;
  localparam int LEB_CYC     = (LEB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OFF_TIME_MS = 1000;
  localparam int OFF_CYC     = CLK_HZ / 1000 * OFF_TIME_MS;
  localparam int AR_CYC      = 8192;
  localparam int UP_RUN      = 8;
  localparam int DN_RUN      = 8;

  localparam logic [10:0] PER_BASE  = 11'(P_PEAK - JIT_CNT);
  localparam logic [4:0]  JIT_TOP   = 5'(2 * JIT_CNT);
  localparam logic [11:0] JIT_LAST  = 12'(JIT_STEP - 1);
  localparam logic [10:0] DMAX_PEAK = 11'(P_PEAK * DUTY_PCT / 100);
  localparam logic [10:0] DMAX_STD  = 11'(2 * P_PEAK * DUTY_PCT / 100);
  localparam logic [4:0]  LEB_LOAD  = 5'(LEB_CYC);
  localparam logic [1:0]  LVL_MAX   = 2'h3;
  localparam logic [3:0]  UP_LAST   = 4'(UP_RUN - 1);
  localparam logic [3:0]  DN_LAST   = 4'(DN_RUN - 1);

  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_ARCNT   = 8'h08;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int ST_GATE = 0;
  localparam int ST_UVLO = 1;
  localparam int ST_OTP  = 2;
  localparam int ST_OTE  = 3;
  localparam int ST_PEAK = 4;
  localparam int ST_LVL  = 8;
  localparam int ST_FSM  = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OCC_PWRUP, OCC_RUN, OCC_AROFF} occ_st_t;

  typedef struct packed {
    logic        en_over;
    logic        i_over;
    logic        supply_low;
    logic        supply_reg;
    logic        temp_over;
    logic        temp_cooled;
    logic        line_low;
    logic        line_absent;
  } occ_sense_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } occ_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } occ_axi_rsp_t;

  typedef struct packed {
    occ_st_t      st;
    logic [10:0]  osc;
    logic [4:0]   jit;
    logic         jup;
    logic [11:0]  jdiv;
    logic         hold;
    logic [10:0]  cyc;
    logic         cpk;
    logic         dmax;
    logic         cstart;
    logic         arm;
    logic         gate;
    logic [4:0]   blank;
    logic [1:0]   level;
    logic         peak;
    logic [3:0]   run_en;
    logic [3:0]   run_sk;
    logic [13:0]  ar;
    logic [26:0]  off;
    logic         uvlo;
    logic         otp;
    logic         ote;
    logic         lock;
    logic         ctrl_en;
    logic [7:0]   awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    occ_axi_rsp_t rsp;
  } occ_state_t;
endpackage
`default_nettype wire

// ===== occ_ctrl.sv
// on/off switch cycle controller with axi4-lite registers
// Function
// R01: free-running oscillator, 264 kHz average at top level, cycle start and max duty.
// R02: period jittered about plus or minus 3 percent, triangle repeating at 1 kHz.
// R03: enable is low while pin current exceeds threshold, high once below it.
// R04: enable sampled at each cycle start; high switches, low skips the cycle.
// R05: enable changes after the sample are ignored; started cycles always complete.
// R06: skipped cycles resample enable at the fast 264 kHz rate.
// R07: enable/skip pattern steps current limit level down and up.
// R08: supply below 4.9 V locks switching out until back at 5.85 V.
// R09: over-temperature disables switching until die cools, then resumes.
// R10: switch current above active threshold ends the pulse for that cycle.
// R11: current limit ignored for the blanking time after turn-on.
// R12: auto-restart counter advances per oscillator cycle, cleared when enable low.
// R13: 8192 cycles without enable low stops switching for one second.
// R14: fault keeps alternating switching and disable periods until regulation returns.
// R15: line undervoltage during disable period halts the auto-restart counter.
// R16: with on-time extension, pulse runs until current limit, not max duty.
// R17: extension off at start-up and after auto-restart until regulation seen.
// R18: power-up and restart need line current above 25 uA to switch.
// R19: during power-up supply held at lockout while line undervoltage persists.
// R20: line sense ignored once switching, looked at again in auto-restart.
// R21: line current below 1 uA means no resistor; undervoltage function off.
// R22: without extension pulse ends at current limit or max duty fall.
// R23: top current limit level runs double frequency; lower levels half that.
// R24: level count and step thresholds are constants; steps at cycle boundaries.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
module occ_ctrl #(
  parameter int AR_CYCLES  = occ_pkg::AR_CYC,
  parameter int OFF_CYCLES = occ_pkg::OFF_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire occ_pkg::occ_sense_t   sense,
  input  wire occ_pkg::occ_axi_req_t axi_req,
  output var  occ_pkg::occ_axi_rsp_t axi_rsp,
  output var  logic                  gate_drive,
  output var  logic                  max_duty_signal,
  output var  logic                  cycle_start,
  output var  logic [1:0]            switch_current_threshold,
  output var  logic                  peak_mode,
  output var  logic                  supply_hold_lockout
);
  import occ_pkg::*;

  localparam logic [13:0] AR_LAST  = 14'(AR_CYCLES - 1);
  localparam logic [26:0] OFF_LAST = 27'(OFF_CYCLES - 1);

  occ_state_t q;
  occ_state_t d;
  logic [10:0] per;
  logic        tick;
  logic        start;
  logic        en_low;
  logic        fault;
  logic        halt;
  logic        ok;
  logic [31:0] rd;
  logic [1:0]  rr;

  always_comb
  begin
    d      = q;
    rd     = '0;
    rr     = RESP_OKAY;
    per    = PER_BASE + {6'h0, q.jit};
    tick   = (q.osc == per - 11'h001);
    start  = tick && !q.hold;
    en_low = sense.en_over; // R03
    halt   = !sense.line_absent && sense.line_low; // R21 R18
    fault  = q.uvlo || q.otp || !q.ctrl_en || (q.st != OCC_RUN); // R08 R09
    ok     = 1'b0;
    d.cstart = 1'b0;

    // fast oscillator with triangle jitter
    if (tick) // R01
    begin
      d.osc = 11'h000;
    end
    else
    begin
      d.osc = q.osc + 11'h001;
    end
    if (q.jdiv == JIT_LAST) // R02
    begin
      d.jdiv = 12'h000;
      if (q.jup)
      begin
        d.jit = q.jit + 5'h01;
        d.jup = (q.jit + 5'h01) != JIT_TOP;
      end
      else
      begin
        d.jit = q.jit - 5'h01;
        d.jup = (q.jit - 5'h01) == 5'h00;
      end
    end
    else
    begin
      d.jdiv = q.jdiv + 12'h001;
    end

    // max duty window of the current cycle
    if (q.cyc != 11'h7ff)
    begin
      d.cyc = q.cyc + 11'h001;
    end
    if (q.dmax && (q.cyc == (q.cpk ? DMAX_PEAK : DMAX_STD) - 11'h001)) // R01
    begin
      d.dmax = 1'b0;
    end

    // supply lockout and thermal latches, set wins
    if (sense.supply_low) // R08
    begin
      d.uvlo = 1'b1;
    end
    else if (sense.supply_reg)
    begin
      d.uvlo = 1'b0;
    end
    if (sense.temp_over) // R09
    begin
      d.otp = 1'b1;
    end
    else if (sense.temp_cooled)
    begin
      d.otp = 1'b0;
    end

    // pulse termination
    if (q.arm)
    begin
      d.arm   = 1'b0;
      d.gate  = !fault;
      d.blank = LEB_LOAD;
    end
    else if (q.gate)
    begin
      if (q.blank != 5'h00) // R11
      begin
        d.blank = q.blank - 5'h01;
      end
      else if (sense.i_over) // R10
      begin
        d.gate = 1'b0;
      end
      if (q.dmax && !d.dmax && !q.ote) // R22 R16
      begin
        d.gate = 1'b0;
      end
      if (fault)
      begin
        d.gate = 1'b0;
      end
    end

    // cycle boundary: sample enable once, step level
    if (tick && q.hold)
    begin
      d.hold = 1'b0; // R05
    end
    else if (start) // R04 R05
    begin
      d.cstart = 1'b1;
      d.cyc    = 11'h000;
      d.dmax   = 1'b1;
      d.gate   = 1'b0;
      ok       = !en_low && !fault;
      if (!en_low) // R07 R24
      begin
        d.run_sk = 4'h0;
        if (q.run_en == UP_LAST)
        begin
          d.run_en = 4'h0;
          if (q.level != LVL_MAX)
          begin
            d.level = q.level + 2'h1;
          end
        end
        else
        begin
          d.run_en = q.run_en + 4'h1;
        end
      end
      else
      begin
        d.run_en = 4'h0;
        if (q.run_sk == DN_LAST)
        begin
          d.run_sk = 4'h0;
          if (q.level != 2'h0)
          begin
            d.level = q.level - 2'h1;
          end
        end
        else
        begin
          d.run_sk = q.run_sk + 4'h1;
        end
      end
      d.peak = (d.level == LVL_MAX); // R23
      d.cpk  = d.peak;
      d.arm  = ok;
      d.hold = ok && !d.peak; // R23 R06
    end

    // auto-restart and power-up sequencing
    d.lock = (q.st == OCC_PWRUP) && halt; // R19
    case (q.st)
      OCC_PWRUP:
      begin
        if (!halt && !q.uvlo) // R19 R18
        begin
          d.st = OCC_RUN;
          d.ar = 14'h0000;
        end
      end
      OCC_RUN:
      begin
        if (en_low) // R12
        begin
          d.ar  = 14'h0000;
          d.ote = 1'b1; // R17
        end
        else if (tick) // R20
        begin
          if (q.ar == AR_LAST) // R13
          begin
            d.st    = OCC_AROFF;
            d.off   = 27'h0;
            d.ote   = 1'b0; // R17
            d.gate  = 1'b0;
            d.arm   = 1'b0;
            d.hold  = 1'b0;
          end
          else
          begin
            d.ar = q.ar + 14'h0001;
          end
        end
      end
      OCC_AROFF:
      begin
        if (halt) // R15
        begin
          d.off = q.off;
        end
        else if (q.off >= OFF_LAST) // R14 R18
        begin
          d.st  = OCC_RUN;
          d.ar  = 14'h0000;
          d.off = 27'h0;
        end
        else
        begin
          d.off = q.off + 27'h1;
        end
      end
      default:
      begin
        d.st = OCC_PWRUP;
      end
    endcase

    // axi4-lite write
    if (axi_req.awvalid && q.rsp.awready)
    begin
      d.rsp.awready = 1'b0;
      d.awaddr      = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready)
    begin
      d.rsp.wready = 1'b0;
      d.wdata      = axi_req.wdata;
      d.wstrb      = axi_req.wstrb;
    end
    if (!q.rsp.awready && !q.rsp.wready && !q.rsp.bvalid)
    begin
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = RESP_OKAY;
      if (q.awaddr == REG_CTRL)
      begin
        if (q.wstrb[0])
        begin
          d.ctrl_en = q.wdata[CTRL_EN_BIT];
        end
      end
      else if (q.awaddr == REG_STATUS || q.awaddr == REG_ARCNT)
      begin
        d.rsp.bresp = RESP_OKAY;
      end
      else
      begin
        d.rsp.bresp = RESP_SLVERR;
      end
    end
    if (q.rsp.bvalid && axi_req.bready)
    begin
      d.rsp.bvalid  = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready  = 1'b1;
    end

    // axi4-lite read
    if (axi_req.araddr == REG_CTRL)
    begin
      rd[CTRL_EN_BIT] = q.ctrl_en;
    end
    else if (axi_req.araddr == REG_STATUS)
    begin
      rd[ST_GATE]         = q.gate;
      rd[ST_UVLO]         = q.uvlo;
      rd[ST_OTP]          = q.otp;
      rd[ST_OTE]          = q.ote;
      rd[ST_PEAK]         = q.peak;
      rd[ST_LVL+1:ST_LVL] = q.level;
      rd[ST_FSM+1:ST_FSM] = q.st;
    end
    else if (axi_req.araddr == REG_ARCNT)
    begin
      rd[13:0] = q.ar;
    end
    else
    begin
      rr = RESP_SLVERR;
    end
    if (axi_req.arvalid && q.rsp.arready)
    begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid  = 1'b1;
      d.rsp.rdata   = rd;
      d.rsp.rresp   = rr;
    end
    if (q.rsp.rvalid && axi_req.rready)
    begin
      d.rsp.rvalid  = 1'b0;
      d.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q             <= '0;
      q.st          <= OCC_PWRUP;
      q.jup         <= 1'b1;
      q.uvlo        <= 1'b1;
      q.ctrl_en     <= CTRL_EN_RST;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign axi_rsp                  = q.rsp;
  assign gate_drive               = q.gate;
  assign max_duty_signal          = q.dmax;
  assign cycle_start              = q.cstart;
  assign switch_current_threshold = q.level;
  assign peak_mode                = q.peak;
  assign supply_hold_lockout      = q.lock;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_gate_after_start: assert property ( // R04
    $rose(gate_drive) |-> $past(cycle_start))
    else $error("gate rose without a cycle start");
  chk_skip_stays_off: assert property ( // R04
    start && sense.en_over |=> !gate_drive ##1 !gate_drive)
    else $error("gate rose in a skipped cycle");
  chk_blank_ignore: assert property ( // R11
    q.gate && !q.arm && q.blank != 5'h00 && !fault && !start |=> gate_drive)
    else $error("pulse ended inside blanking time");
  chk_ilim_off: assert property ( // R10
    q.gate && !q.arm && q.blank == 5'h00 && sense.i_over |=> !gate_drive)
    else $error("current limit did not end pulse");
  chk_dmax_end: assert property ( // R22
    $fell(max_duty_signal) && !$past(q.ote) |-> !gate_drive)
    else $error("pulse outlived max duty");
  chk_ote_hold: assert property ( // R16
    q.gate && q.ote && q.dmax && !d.dmax && q.blank == 5'h00 && !sense.i_over
      && !fault && !start |=> gate_drive)
    else $error("extended pulse cut at max duty");
  chk_uvlo_block: assert property ( // R08
    q.uvlo |=> !gate_drive)
    else $error("switching during supply lockout");
  chk_otp_block: assert property ( // R09
    q.otp |=> !gate_drive)
    else $error("switching during thermal shutdown");
  chk_ar_entry: assert property ( // R13
    q.st == OCC_RUN && tick && q.ar == AR_LAST && !en_low
      |=> q.st == OCC_AROFF && !q.ote ##1 !gate_drive)
    else $error("auto-restart not entered");
  chk_ar_halt: assert property ( // R15
    q.st == OCC_AROFF && halt |=> $stable(q.off) && q.st == OCC_AROFF)
    else $error("disable timer ran during line undervoltage");
  chk_ar_clear: assert property ( // R12
    q.st == OCC_RUN && en_low |=> q.ar == 14'h0000 && q.ote)
    else $error("auto-restart counter not cleared");
  chk_fast_resample: assert property ( // R06
    start && sense.en_over |=> !q.hold)
    else $error("skipped cycle held for slow period");
  chk_lock_hold: assert property ( // R19
    q.st == OCC_PWRUP && halt |=> supply_hold_lockout && q.st == OCC_PWRUP)
    else $error("power-up left during line undervoltage");

  cov_pulse: cover property ($rose(gate_drive) ##[1:400] $fell(gate_drive));
  cov_peak: cover property ($rose(peak_mode));
  cov_ar_enter: cover property (q.st == OCC_RUN ##1 q.st == OCC_AROFF);
  cov_ar_leave: cover property (q.st == OCC_AROFF ##1 q.st == OCC_RUN);
endmodule
`default_nettype wire

// ===== occ_opto_model.sv
// optocoupler feedback model driving the enable pin current flag
`default_nettype none
module occ_opto_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pull,
  input  wire logic [2:0] lag,
  output var  logic       en_over
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dly_q;
  // transistor response lag, zero for a prompt answer
  always_ff @(posedge clk)
  begin
    if (rst)
      dly_q <= 8'h00;
    else
      dly_q <= {dly_q[6:0], pull};
  end
  assign en_over = (lag == 3'h0) ? pull : dly_q[lag - 3'h1];
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the on/off switch cycle controller
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import occ_pkg::*;
  localparam int AR_N  = 64;
  localparam int OFF_N = 200;
  localparam int TMO   = 95000;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
    logic [31:0] mask;
  } occ_row_t;
  logic         clk;
  logic         rst;
  occ_sense_t   sns;
  occ_axi_req_t req;
  occ_axi_rsp_t rsp;
  logic         gate;
  logic         dmax;
  logic         cst;
  logic [1:0]   lvl;
  logic         peak;
  logic         hold;
  logic         pull;
  logic [2:0]   lag;
  logic         en_over_w;
  logic [1:0]   r;
  logic [31:0]  q;
  int           n;
  int           g;
  int           cyc_n;
  int           error_cnt;
  int           comparisons;
  longint       t0;
  occ_row_t     rows [8] = '{
    '{1'b0, REG_CTRL, 32'h1, RESP_OKAY, 32'h1},
    '{1'b1, REG_CTRL, 32'h0, RESP_OKAY, 32'h0},
    '{1'b0, REG_CTRL, 32'h0, RESP_OKAY, 32'h1},
    '{1'b1, REG_CTRL, 32'h1, RESP_OKAY, 32'h0},
    '{1'b0, REG_STATUS, 32'h2, RESP_OKAY, 32'h3007},
    '{1'b1, REG_STATUS, 32'hf, RESP_OKAY, 32'h0},
    '{1'b0, 8'h0c, 32'h0, RESP_SLVERR, 32'hffffffff},
    '{1'b1, 8'h10, 32'h0, RESP_SLVERR, 32'h0}
  };

  occ_ctrl #(.AR_CYCLES(AR_N), .OFF_CYCLES(OFF_N)) uut (
    .clk(clk), .rst(rst), .sense({en_over_w, sns[6:0]}), .axi_req(req),
    .axi_rsp(rsp), .gate_drive(gate), .max_duty_signal(dmax), .cycle_start(cst),
    .switch_current_threshold(lvl), .peak_mode(peak), .supply_hold_lockout(hold));
  occ_opto_model opto (.clk(clk), .rst(rst), .pull(pull), .lag(lag), .en_over(en_over_w));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == TMO)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (w)
    begin
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
    end
    else
    begin
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
    end
    do
    begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end while (!(w ? rsp.bvalid : rsp.rvalid));
    r = w ? rsp.bresp : rsp.rresp;
    q = rsp.rdata;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask

  task automatic wst(input logic [1:0] s, input int lim);
    int k;
    k = 0;
    do
    begin
      axi(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (q[13:12] !== s && k < lim);
    `CHK(q[13:12], s)
  endtask

  task automatic wcs();
    do @(negedge clk); while (cst !== 1'b1);
  endtask

  task automatic nclk(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic gap();
    n = 0;
    g = 0;
    do
    begin
      @(negedge clk);
      n++;
      g += int'(gate === 1'b1);
    end while (cst !== 1'b1);
  endtask

  task automatic watch(input int c);
    g = 0;
    repeat (c)
    begin
      @(negedge clk);
      g += int'(gate === 1'b1);
    end
  endtask

  initial
  begin
    rst = 1'b1;
    req = '0;
    sns = '0;
    sns.line_low = 1'b1;
    pull = 1'b0;
    lag = 3'h0;
    cyc_n = 0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      axi(rows[i].wr, rows[i].addr, rows[i].data);
      `CHK(r, rows[i].resp)
      `CHK(q & rows[i].mask, rows[i].data & rows[i].mask)
    end
    @(posedge clk);
    sns.supply_reg <= 1'b1;
    nclk(30);
    `CHK(hold, 1'b1)
    wst(2'h0, 1);
    @(posedge clk);
    sns.line_low <= 1'b0;
    wst(2'h1, 10);
    `CHK(hold, 1'b0)
    `CHK(q[1], 1'b0)
    wcs();
    @(negedge clk);
    `CHK(gate, 1'b1)
    do @(negedge clk); while (dmax === 1'b1);
    `CHK(gate, 1'b0)
    wcs();
    @(posedge clk);
    sns.i_over <= 1'b1;
    nclk(19);
    `CHK(gate, 1'b1)
    nclk(4);
    `CHK(gate, 1'b0)
    @(posedge clk);
    sns.i_over <= 1'b0;
    lag <= 3'h4;
    wcs();
    nclk(5);
    @(posedge clk);
    pull <= 1'b1;
    nclk(30);
    `CHK(gate, 1'b1)
    axi(1'b0, REG_ARCNT, 32'h0);
    `CHK(q[13:0], 14'h0)
    wcs();
    gap();
    `CHK(g, 0)
    `CHK(n >= 367 && n <= 389, 1'b1)
    @(posedge clk);
    pull <= 1'b0;
    for (int k = 1; k <= 24; k++)
    begin
      wcs();
      if (k == 5)
        `CHK(($time - t0) >= 7340 && ($time - t0) <= 7780, 1'b1)
      t0 = $time;
      nclk(3);
      `CHK(lvl, 2'(k / 8))
      if (k == 1)
      begin
        do @(negedge clk); while (dmax === 1'b1);
        `CHK(gate, 1'b1)
      end
    end
    `CHK(peak, 1'b1)
    wcs();
    gap();
    `CHK(n >= 367 && n <= 389, 1'b1)
    @(posedge clk);
    sns.line_low <= 1'b1;
    wst(2'h1, 1);
    wst(2'h2, 4000);
    `CHK(gate, 1'b0)
    nclk(400);
    wst(2'h2, 1);
    @(posedge clk);
    sns.line_absent <= 1'b1;
    wst(2'h1, 150);
    `CHK(q[3], 1'b0)
    wst(2'h2, 12000);
    @(posedge clk);
    pull <= 1'b1;
    wst(2'h1, 150);
    @(posedge clk);
    pull <= 1'b0;
    sns.temp_over <= 1'b1;
    @(posedge clk);
    sns.temp_over <= 1'b0;
    axi(1'b0, REG_STATUS, 32'h0);
    `CHK(q[2], 1'b1)
    watch(800);
    `CHK(g, 0)
    @(posedge clk);
    sns.temp_cooled <= 1'b1;
    watch(800);
    `CHK(g != 0, 1'b1)
    @(posedge clk);
    sns.temp_cooled <= 1'b0;
    sns.supply_reg <= 1'b0;
    sns.supply_low <= 1'b1;
    @(posedge clk);
    sns.supply_low <= 1'b0;
    axi(1'b0, REG_STATUS, 32'h0);
    `CHK(q[1], 1'b1)
    watch(800);
    `CHK(g, 0)
    @(posedge clk);
    sns.supply_reg <= 1'b1;
    watch(800);
    `CHK(g != 0, 1'b1)
    axi(1'b1, REG_CTRL, 32'h0);
    watch(800);
    `CHK(g, 0)
    axi(1'b1, REG_CTRL, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    `CHK({gate, lvl, peak}, 4'h0)
    @(posedge clk);
    rst <= 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
